// file: rtl/rgfs_pkg.sv
// rgfs_pkg: shared constants and types for the read gate / focus sequencer
// What this block does
// [R1] trigger sensor edge opens read interval
// [R2] start command also opens read interval
// [R3] auto-pulse generates gate from on/off counts
// [R4] stop by trigger, command, timer or condition
// [R5] learn background, detect object by deviation
// [R6] environment keeps one object per cycle
// [R7] refocus from park, apply time/distance hold-off
// [R8] focus target is distance plus offset
// [R9] eight stored distance configurations, any order
// [R10] switching input selects among two stages
// [R11] command or timer steps eight levels
// [R12] mirror dead centres act as switch events
// [R13] assignment table maps step to configuration
// [R14] redundant start or stray stop ignored
`default_nettype none
package rgfs_pkg;
    localparam int DIST_W   = 16;
    localparam int CNT_W    = 24;
    localparam int STEP_W   = 3;
    localparam int N_CFG    = 8;
    localparam logic [STEP_W-1:0] STEP_ZERO = 3'h0;
    localparam logic [STEP_W-1:0] STEP_MAX  = 3'h7;
    localparam logic [STEP_W-1:0] STEP_TWO_MAX = 3'h1;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 24'h000001;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 24'h000000;
    localparam logic [DIST_W-1:0] DIST_ZERO = 16'h0000;
    // start source select
    localparam logic [1:0] SRC_SENSOR = 2'h0;
    localparam logic [1:0] SRC_CMD    = 2'h1;
    localparam logic [1:0] SRC_AUTO   = 2'h2;
    // stop source enables (bit positions)
    localparam int STOP_TRIG = 0;
    localparam int STOP_CMD  = 1;
    localparam int STOP_TMR  = 2;
    localparam int STOP_COND = 3;
    // focus mode and switch source
    localparam logic [1:0] FSW_INPUT  = 2'h0;
    localparam logic [1:0] FSW_CMD    = 2'h1;
    localparam logic [1:0] FSW_TIMER  = 2'h2;
    localparam logic [1:0] FSW_MIRROR = 2'h3;

    typedef enum logic [1:0] {
        RGFS_IDLE  = 2'b00,
        RGFS_OPEN  = 2'b01,
        RGFS_LEARN = 2'b10
    } rgfs_gate_type;

    typedef struct packed {
        logic [1:0]       start_src;
        logic [3:0]       stop_en;
        logic [CNT_W-1:0] gate_time;
        logic [CNT_W-1:0] auto_on;
        logic [CNT_W-1:0] auto_off;
    } rgfs_gate_cfg_type;

    typedef struct packed {
        logic              auto_focus;
        logic [1:0]        sw_src;
        logic [DIST_W-1:0] park;
        logic [DIST_W-1:0] offset;
        logic [DIST_W-1:0] diff_thr;
        logic [DIST_W-1:0] hyst;
        logic [CNT_W-1:0]  hold_time;
        logic [CNT_W-1:0]  step_time;
    } rgfs_focus_cfg_type;
endpackage : rgfs_pkg
`default_nettype wire

// file: rtl/rgfs_auto_pulse.sv
// rgfs_auto_pulse: internal periodic gate with programmable on/off counts
`default_nettype none
module rgfs_auto_pulse
    import rgfs_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] on_cnt,
    input  wire logic [CNT_W-1:0] off_cnt,
    output logic                  pulse_on
);
    logic [CNT_W-1:0] cnt;
    logic             phase_on;
    wire  [CNT_W-1:0] limit   = phase_on ? on_cnt : off_cnt;
    wire              at_end  = (cnt + CNT_ONE) >= limit;

    // [R3]
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt      <= CNT_ZERO;
            phase_on <= 1'b0;
        end else if (!enable) begin
            cnt      <= CNT_ZERO;
            phase_on <= 1'b0;
        end else if (at_end) begin
            cnt      <= CNT_ZERO;
            phase_on <= ~phase_on;
        end else begin
            cnt      <= cnt + CNT_ONE;
        end
    end
    assign pulse_on = phase_on;

    property p_auto_off;
        @(posedge ref_clk) disable iff (rst)
        !enable |=> !pulse_on;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("auto pulse on while disabled"); // [R3]
endmodule : rgfs_auto_pulse
`default_nettype wire

// file: rtl/rgfs_top.sv
// rgfs_top: read gate control and focus position sequencing
`default_nettype none
module rgfs_top
    import rgfs_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire rgfs_gate_cfg_type  gate_cfg,
    input  wire rgfs_focus_cfg_type focus_cfg,
    input  wire logic               trig_sensor,
    input  wire logic               cmd_start,
    input  wire logic               cmd_stop,
    input  wire logic               eval_cond,
    input  wire logic               learn_req,
    input  wire logic               dist_valid,
    input  wire logic [DIST_W-1:0]  dist_meas,
    input  wire logic               switch_in,
    input  wire logic               cmd_focus_step,
    input  wire logic               mirror_dead_ctr,
    input  wire logic               cfg_wr,
    input  wire logic [STEP_W-1:0]  cfg_wr_idx,
    input  wire logic [DIST_W-1:0]  cfg_wr_dist,
    input  wire logic               map_wr,
    input  wire logic [STEP_W-1:0]  map_wr_step,
    input  wire logic [STEP_W-1:0]  map_wr_cfg,
    output logic                    read_gate,
    output logic                    gate_open_pulse,
    output logic                    gate_close_pulse,
    output logic                    bg_learned,
    output logic                    object_seen,
    output logic [DIST_W-1:0]       focus_pos,
    output logic [STEP_W-1:0]       focus_step
);
    // =========================================================
    // gate sequencing
    rgfs_gate_type    state;
    rgfs_gate_type    next_state;
    logic             trig_d;
    logic             auto_d;
    logic [CNT_W-1:0] gate_cnt;
    logic             auto_pulse;

    rgfs_auto_pulse u_auto (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .enable   (gate_cfg.start_src == SRC_AUTO),
        .on_cnt   (gate_cfg.auto_on),
        .off_cnt  (gate_cfg.auto_off),
        .pulse_on (auto_pulse)
    );

    wire trig_rise = trig_sensor & ~trig_d;
    wire trig_fall = ~trig_sensor & trig_d;
    wire auto_rise = auto_pulse & ~auto_d;
    wire auto_fall = ~auto_pulse & auto_d;
    wire is_open   = (state == RGFS_OPEN);

    // sensor object arrival or command, or auto pulse rising
    wire start_ev = (gate_cfg.start_src == SRC_SENSOR) ? trig_rise :      // [R1]
                    (gate_cfg.start_src == SRC_CMD)    ? cmd_start :      // [R2]
                    (gate_cfg.start_src == SRC_AUTO)   ? auto_rise : 1'b0; // [R3]
    wire src_end  = (gate_cfg.start_src == SRC_AUTO) ? auto_fall : trig_fall;
    wire tmr_end  = (gate_cnt + CNT_ONE) >= gate_cfg.gate_time;
    wire stop_ev  = (gate_cfg.stop_en[STOP_TRIG] & src_end)                // [R4]
                  | (gate_cfg.stop_en[STOP_CMD]  & cmd_stop)
                  | (gate_cfg.stop_en[STOP_TMR]  & tmr_end)
                  | (gate_cfg.stop_en[STOP_COND] & eval_cond);

    // learning only outside a read interval; start while open ignored
    always_comb begin
        next_state = state;
        case (state)
            RGFS_IDLE: begin
                if (learn_req)
                    next_state = RGFS_LEARN;
                else if (start_ev)
                    next_state = RGFS_OPEN;
            end
            RGFS_OPEN: begin
                if (stop_ev)                                               // [R14]
                    next_state = RGFS_IDLE;
            end
            RGFS_LEARN: begin
                if (dist_valid)
                    next_state = RGFS_IDLE;
            end
            default: next_state = RGFS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state            <= RGFS_IDLE;
            trig_d           <= 1'b0;
            auto_d           <= 1'b0;
            gate_cnt         <= CNT_ZERO;
            gate_open_pulse  <= 1'b0;
            gate_close_pulse <= 1'b0;
        end else begin
            state            <= next_state;
            trig_d           <= trig_sensor;
            auto_d           <= auto_pulse;
            gate_cnt         <= is_open ? gate_cnt + CNT_ONE : CNT_ZERO;
            gate_open_pulse  <= (state != RGFS_OPEN) && (next_state == RGFS_OPEN);
            gate_close_pulse <= is_open && (next_state != RGFS_OPEN);
        end
    end
    assign read_gate = is_open;

    // =========================================================
    // autofocus: background learning and object detection
    logic [DIST_W-1:0] bg_dist;
    logic [DIST_W-1:0] last_target;
    logic [CNT_W-1:0]  hold_cnt;
    logic [DIST_W-1:0] af_focus;

    wire [DIST_W-1:0] diff_bg = (dist_meas > bg_dist) ? dist_meas - bg_dist
                                                       : bg_dist - dist_meas;
    wire obj_det      = bg_learned & dist_valid & (diff_bg > focus_cfg.diff_thr); // [R5]
    wire [DIST_W-1:0] target = dist_meas + focus_cfg.offset;                     // [R8]
    wire [DIST_W-1:0] tgt_delta = (target > last_target) ? target - last_target
                                                          : last_target - target;
    wire hold_done    = hold_cnt == CNT_ZERO;
    wire move_ok      = hold_done & (tgt_delta > focus_cfg.hyst);                // [R7]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bg_dist     <= DIST_ZERO;
            bg_learned  <= 1'b0;
            object_seen <= 1'b0;
            last_target <= DIST_ZERO;
            hold_cnt    <= CNT_ZERO;
            af_focus    <= DIST_ZERO;
        end else begin
            if (state == RGFS_LEARN && dist_valid) begin                         // [R5]
                bg_dist    <= dist_meas;
                bg_learned <= 1'b1;
            end
            object_seen <= obj_det & is_open;
            if (gate_open_pulse) begin                                           // [R7]
                af_focus    <= focus_cfg.park;
                last_target <= focus_cfg.park;
                hold_cnt    <= CNT_ZERO;
            end else if (is_open && obj_det && move_ok) begin
                af_focus    <= target;                                           // [R8]
                last_target <= target;
                hold_cnt    <= focus_cfg.hold_time;
            end else if (!hold_done) begin
                hold_cnt    <= hold_cnt - CNT_ONE;
            end
        end
    end

    // =========================================================
    // switched focus: stored configs, assignment table, step source
    logic [DIST_W-1:0] cfg_dist [N_CFG];                                         // [R9]
    logic [STEP_W-1:0] step_map [N_CFG];                                         // [R13]
    logic [STEP_W-1:0] step;
    logic [CNT_W-1:0]  step_cnt;
    logic              mirror_d;

    function automatic logic [STEP_W-1:0] rgfs_wrap(input logic [STEP_W-1:0] s,
                                                    input logic [STEP_W-1:0] top);
        rgfs_wrap = (s >= top) ? STEP_ZERO : s + 3'h1;
    endfunction : rgfs_wrap

    wire mirror_ev = mirror_dead_ctr & ~mirror_d;                                 // [R12]
    wire tmr_ev    = (step_cnt + CNT_ONE) >= focus_cfg.step_time;
    wire adv_ev    = (focus_cfg.sw_src == FSW_CMD)    ? cmd_focus_step :          // [R11]
                     (focus_cfg.sw_src == FSW_TIMER)  ? tmr_ev :
                     (focus_cfg.sw_src == FSW_MIRROR) ? mirror_ev : 1'b0;
    wire [STEP_W-1:0] in_step = switch_in ? STEP_TWO_MAX : STEP_ZERO;              // [R10]

    genvar gi;
    generate
        for (gi = 0; gi < N_CFG; gi++) begin : g_tab
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    cfg_dist[gi] <= DIST_ZERO;
                    step_map[gi] <= STEP_W'(gi);
                end else begin
                    if (cfg_wr && cfg_wr_idx == STEP_W'(gi))
                        cfg_dist[gi] <= cfg_wr_dist;
                    if (map_wr && map_wr_step == STEP_W'(gi))
                        step_map[gi] <= map_wr_cfg;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            step     <= STEP_ZERO;
            step_cnt <= CNT_ZERO;
            mirror_d <= 1'b0;
        end else begin
            mirror_d <= mirror_dead_ctr;
            step_cnt <= (tmr_ev || !is_open) ? CNT_ZERO : step_cnt + CNT_ONE;
            if (focus_cfg.sw_src == FSW_INPUT)
                step <= in_step;                                                   // [R10]
            else if (gate_open_pulse)
                step <= STEP_ZERO;
            else if (is_open && adv_ev)
                step <= rgfs_wrap(step, STEP_MAX);                                 // [R11]
        end
    end

    wire [DIST_W-1:0] sw_focus = cfg_dist[step_map[step]];                         // [R13]

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            focus_pos  <= DIST_ZERO;
            focus_step <= STEP_ZERO;
        end else begin
            focus_pos  <= focus_cfg.auto_focus ? af_focus : sw_focus;
            focus_step <= step;
        end
    end

    // =========================================================
    // checks
    sequence s_trig_rise;
        trig_sensor && !trig_d;
    endsequence
    property p_sensor_open;
        @(posedge ref_clk) disable iff (rst)
        (state == RGFS_IDLE && !learn_req && gate_cfg.start_src == SRC_SENSOR)
            ##0 s_trig_rise |=> read_gate;
    endproperty
    a_sensor_open: assert property (p_sensor_open) else $error("sensor did not open"); // [R1]

    property p_cmd_open;
        @(posedge ref_clk) disable iff (rst)
        (state == RGFS_IDLE && !learn_req && gate_cfg.start_src == SRC_CMD && cmd_start)
            |=> read_gate;
    endproperty
    a_cmd_open: assert property (p_cmd_open) else $error("command did not open"); // [R2]

    property p_auto_gate;
        @(posedge ref_clk) disable iff (rst)
        (gate_cfg.start_src == SRC_AUTO && state == RGFS_IDLE && !learn_req && auto_rise)
            |=> read_gate;
    endproperty
    a_auto_gate: assert property (p_auto_gate) else $error("auto pulse missed"); // [R3]

    property p_stop_cmd;
        @(posedge ref_clk) disable iff (rst)
        (read_gate && gate_cfg.stop_en[STOP_CMD] && cmd_stop) |=> !read_gate && gate_close_pulse;
    endproperty
    a_stop_cmd: assert property (p_stop_cmd) else $error("stop command ignored"); // [R4]

    property p_learn;
        @(posedge ref_clk) disable iff (rst)
        (state == RGFS_LEARN && dist_valid) |=> bg_learned && bg_dist == $past(dist_meas);
    endproperty
    a_learn: assert property (p_learn) else $error("background not stored"); // [R5]

    property p_park;
        @(posedge ref_clk) disable iff (rst)
        (gate_open_pulse && focus_cfg.auto_focus) |=> af_focus == $past(focus_cfg.park);
    endproperty
    a_park: assert property (p_park) else $error("park not applied"); // [R7]

    property p_offset;
        @(posedge ref_clk) disable iff (rst)
        (is_open && obj_det && move_ok && !gate_open_pulse)
            |=> af_focus == $past(dist_meas) + $past(focus_cfg.offset);
    endproperty
    a_offset: assert property (p_offset) else $error("focus target wrong"); // [R8]

    property p_two_stage;
        @(posedge ref_clk) disable iff (rst)
        focus_cfg.sw_src == FSW_INPUT |=> step == ($past(switch_in) ? STEP_TWO_MAX : STEP_ZERO);
    endproperty
    a_two_stage: assert property (p_two_stage) else $error("input stage above two"); // [R10]

    property p_timer_stop;
        @(posedge ref_clk) disable iff (rst)
        (read_gate && gate_cfg.stop_en[STOP_TMR] && tmr_end) |=> !read_gate && gate_close_pulse;
    endproperty
    a_timer_stop: assert property (p_timer_stop) else $error("timer did not close"); // [R4]

    property p_cond_stop;
        @(posedge ref_clk) disable iff (rst)
        (read_gate && gate_cfg.stop_en[STOP_COND] && eval_cond) |=> !read_gate;
    endproperty
    a_cond_stop: assert property (p_cond_stop) else $error("condition did not close"); // [R4]

    // hold-off keeps the lens still even when a far object shows up
    property p_hold;
        @(posedge ref_clk) disable iff (rst)
        (!hold_done && !gate_open_pulse) |=> af_focus == $past(af_focus);
    endproperty
    a_hold: assert property (p_hold) else $error("focus moved during hold-off"); // [R7]

    sequence s_mirror_rise;
        mirror_dead_ctr && !mirror_d;
    endsequence
    property p_mirror_step;
        @(posedge ref_clk) disable iff (rst)
        (is_open && !gate_open_pulse && focus_cfg.sw_src == FSW_MIRROR)
            ##0 s_mirror_rise |=> step != $past(step);
    endproperty
    a_mirror_step: assert property (p_mirror_step) else $error("dead centre missed"); // [R12]

    property p_step_wrap;
        @(posedge ref_clk) disable iff (rst)
        (is_open && !gate_open_pulse && focus_cfg.sw_src == FSW_CMD && cmd_focus_step
            && step == STEP_MAX) |=> step == STEP_ZERO;
    endproperty
    a_step_wrap: assert property (p_step_wrap) else $error("step did not wrap"); // [R11]

    property p_step_frozen;
        @(posedge ref_clk) disable iff (rst)
        (!read_gate && focus_cfg.sw_src != FSW_INPUT) |=> step == $past(step);
    endproperty
    a_step_frozen: assert property (p_step_frozen) else $error("step moved while closed"); // [R14]

    property p_no_restart;
        @(posedge ref_clk) disable iff (rst)
        (read_gate && !stop_ev) |=> read_gate && !gate_open_pulse;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("gate dropped or restarted"); // [R14]
endmodule : rgfs_top
`default_nettype wire

// file: sim/rgfs_host_model.sv
// rgfs_host_model: trigger sensor and host command source in front of rgfs_top
`default_nettype none
module rgfs_host_model (
    input  wire logic ref_clk,
    output var logic  trig_sensor,
    output var logic  cmd_start,
    output var logic  cmd_stop,
    output var logic  cmd_focus_step
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        trig_sensor = 1'b0;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        cmd_focus_step = 1'b0;
    end

    // level stays high while the single object sits in the field
    task automatic object_in(input logic v);
        @(negedge ref_clk);
        trig_sensor = v;
    endtask : object_in

    task automatic start_cmd();
        @(negedge ref_clk);
        cmd_start = 1'b1;
        @(negedge ref_clk);
        cmd_start = 1'b0;
    endtask : start_cmd

    task automatic stop_cmd();
        @(negedge ref_clk);
        cmd_stop = 1'b1;
        @(negedge ref_clk);
        cmd_stop = 1'b0;
    endtask : stop_cmd

    task automatic step_cmd();
        @(negedge ref_clk);
        cmd_focus_step = 1'b1;
        @(negedge ref_clk);
        cmd_focus_step = 1'b0;
    endtask : step_cmd
endmodule : rgfs_host_model
`default_nettype wire

// file: sim/rgfs_top_tb.sv
// rgfs_top_tb: self-checking bench for read gate and focus sequencing
`default_nettype none
module rgfs_top_tb
    import rgfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, eval_cond, learn_req, dist_valid, switch_in, mirror_dead_ctr;
    logic cfg_wr, map_wr, read_gate, gop, gcp, bg_learned, object_seen;
    wire logic trig_sensor, cmd_start, cmd_stop, cmd_focus_step;
    rgfs_gate_cfg_type  g;
    rgfs_focus_cfg_type f;
    logic [DIST_W-1:0] dist_meas, cfg_wr_dist, focus_pos, bg, dm;
    logic [STEP_W-1:0] cfg_wr_idx, map_wr_step, map_wr_cfg, focus_step;
    logic [DIST_W-1:0] cfg_d [8];
    logic [STEP_W-1:0] map_t [8];
    int err_count, total_checks, n_open, n_close, n_obj, n, hi, lo;

    rgfs_host_model host (.ref_clk(ref_clk), .trig_sensor(trig_sensor), .cmd_start(cmd_start),
        .cmd_stop(cmd_stop), .cmd_focus_step(cmd_focus_step));
    rgfs_top DUT (.ref_clk(ref_clk), .rst(rst), .gate_cfg(g), .focus_cfg(f),
        .trig_sensor(trig_sensor), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
        .eval_cond(eval_cond), .learn_req(learn_req), .dist_valid(dist_valid),
        .dist_meas(dist_meas), .switch_in(switch_in), .cmd_focus_step(cmd_focus_step),
        .mirror_dead_ctr(mirror_dead_ctr), .cfg_wr(cfg_wr), .cfg_wr_idx(cfg_wr_idx),
        .cfg_wr_dist(cfg_wr_dist), .map_wr(map_wr), .map_wr_step(map_wr_step),
        .map_wr_cfg(map_wr_cfg), .read_gate(read_gate), .gate_open_pulse(gop),
        .gate_close_pulse(gcp), .bg_learned(bg_learned), .object_seen(object_seen),
        .focus_pos(focus_pos), .focus_step(focus_step));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        n_open += (gop === 1'b1);
        n_close += (gcp === 1'b1);
        n_obj += (object_seen === 1'b1);
    end

    // ==========================================================
    // helpers
    function automatic logic [DIST_W-1:0] exp_pos(input int s);
        return cfg_d[map_t[s % 8]];
    endfunction : exp_pos

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc

    // bounded so a stuck gate cannot hang the run
    task automatic run_len(input logic lvl, output int k);
        k = 0;
        while (read_gate === lvl && k < 200) begin
            cyc(1);
            k++;
        end
    endtask : run_len

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (6000) @(posedge ref_clk);
        err_count++;
        test_done();
    end

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(64));
        {rst, g, f} = '1;
        {g, f, eval_cond, learn_req, dist_valid, switch_in, mirror_dead_ctr} = '0;
        {cfg_wr, map_wr, dist_meas, cfg_wr_dist, cfg_wr_idx, map_wr_step, map_wr_cfg} = '0;
        rst = 1'b1;
        cyc(8);
        rst = 1'b0;
        chk({read_gate, bg_learned, focus_pos, focus_step}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            cfg_d[i] = DIST_W'($urandom);
            map_t[i] = STEP_W'($urandom);
            {cfg_wr, cfg_wr_idx, cfg_wr_dist} = {1'b1, STEP_W'(i), cfg_d[i]};
            {map_wr, map_wr_step, map_wr_cfg} = {1'b1, STEP_W'(i), map_t[i]};
            cyc(1);
        end
        {cfg_wr, map_wr} = 2'b00;
        {n_open, n_close} = 0;
        // command start/stop with redundant events
        g.start_src = SRC_CMD;
        g.stop_en = 4'h2;
        host.start_cmd();
        chk(read_gate, 1);
        host.start_cmd();
        cyc(2);
        chk(n_open, 1);
        host.stop_cmd();
        chk(read_gate, 0);
        host.stop_cmd();
        cyc(2);
        chk(n_close, 1);
        // sensor edges
        g.start_src = SRC_SENSOR;
        g.stop_en = 4'h1;
        host.object_in(1'b1);
        cyc(1);
        chk(read_gate, 1);
        cyc(3);
        host.object_in(1'b0);
        cyc(1);
        chk(read_gate, 0);
        // timer stop with random length
        g.start_src = SRC_CMD;
        g.stop_en = 4'h4;
        g.gate_time = CNT_W'(4 + $urandom_range(3));
        host.start_cmd();
        run_len(1'b1, n);
        chk(n, g.gate_time);
        // disabled stop source ignored, condition stop taken
        g.stop_en = 4'h8;
        host.start_cmd();
        host.stop_cmd();
        chk(read_gate, 1);
        eval_cond = 1'b1;
        cyc(1);
        eval_cond = 1'b0;
        chk(read_gate, 0);
        // internal periodic gate
        g.auto_on = CNT_W'(2 + $urandom_range(3));
        g.auto_off = CNT_W'(3 + $urandom_range(3));
        g.stop_en = 4'h1;
        g.start_src = SRC_AUTO;
        run_len(1'b0, n);
        run_len(1'b1, hi);
        run_len(1'b0, lo);
        chk(hi, g.auto_on);
        chk(lo, g.auto_off);
        // the gate is open again here; pulling the source now would strand it
        run_len(1'b1, n);
        chk(n, g.auto_on);
        g.start_src = 2'h3;
        cyc(12);
        chk(read_gate, 0);
        // switched focus by command through the table
        g.start_src = SRC_CMD;
        g.stop_en = 4'h2;
        f.sw_src = FSW_CMD;
        host.start_cmd();
        cyc(3);
        chk(focus_pos, exp_pos(0));
        for (int k = 1; k <= 8; k++) begin
            host.step_cmd();
            cyc(3);
            chk({focus_step, focus_pos}, {STEP_W'(k % 8), exp_pos(k)});
        end
        host.stop_cmd();
        host.step_cmd();
        cyc(3);
        chk(focus_step, 0);
        // mirror turning points, then timer stepping
        f.sw_src = FSW_MIRROR;
        host.start_cmd();
        // the open pulse rearms step 0, so stay clear of that cycle
        cyc(1);
        for (int k = 1; k <= 3; k++) begin
            mirror_dead_ctr = 1'b1;
            cyc(2);
            mirror_dead_ctr = 1'b0;
            cyc(2);
            chk({focus_step, focus_pos}, {STEP_W'(k), exp_pos(k)});
        end
        host.stop_cmd();
        f.sw_src = FSW_TIMER;
        f.step_time = 24'h000004;
        host.start_cmd();
        n = 0;
        while (focus_step !== 3'h2 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(focus_step, 2);
        // two step periods of 4, the first including the rearm cycle, then the output register
        chk(n, 9);
        host.stop_cmd();
        // two-stage input
        f.sw_src = FSW_INPUT;
        switch_in = 1'b1;
        cyc(3);
        chk({focus_step, focus_pos}, {3'h1, exp_pos(1)});
        switch_in = 1'b0;
        cyc(3);
        chk(focus_step, 0);
        // autofocus: learn, ignore background, track object plus offset
        f = '0;
        f.auto_focus = 1'b1;
        // park kept above every target so the first move clears hysteresis
        f.park = 16'h8000 | DIST_W'($urandom);
        f.offset = DIST_W'($urandom_range(255));
        {f.diff_thr, f.hyst, f.hold_time} = {16'h0010, 16'h0004, 24'h000002};
        bg = 16'h8000;
        {learn_req, dist_valid, dist_meas} = {2'b11, bg};
        cyc(1);
        learn_req = 1'b0;
        cyc(3);
        dist_valid = 1'b0;
        cyc(4);
        chk(bg_learned, 1);
        n_obj = 0;
        host.start_cmd();
        cyc(3);
        chk(focus_pos, f.park);
        {dist_valid, dist_meas} = {1'b1, bg + 16'h0001};
        cyc(1);
        dist_valid = 1'b0;
        cyc(3);
        chk(focus_pos, f.park);
        chk(n_obj, 0);
        dm = bg - 16'h1000;
        {dist_valid, dist_meas} = {1'b1, dm};
        cyc(1);
        // a new distance right after the move falls inside the hold-off
        dist_meas = dm - 16'h0100;
        cyc(1);
        dist_valid = 1'b0;
        cyc(3);
        chk(focus_pos, dm + f.offset);
        chk(n_obj, 2);
        {dist_valid, dist_meas} = {1'b1, dm - 16'h0100};
        cyc(1);
        dist_valid = 1'b0;
        cyc(3);
        chk(focus_pos, dm - 16'h0100 + f.offset);
        host.stop_cmd();
        host.start_cmd();
        cyc(3);
        chk(focus_pos, f.park);
        test_done();
    end
endmodule : rgfs_top_tb
`default_nettype wire
